/* src/lsc_comparator.sv */
/*
 * label stack comparator stage: walks up to four labels and an
 * optional control word, matches eight flows, reports next offset.
 * assumes words arrive one per valid cycle from the previous stage,
 * first label flagged by stk_start_i; registers over classic wishbone.
 */
`timescale 1ns/100ps
`include "lsc_defines.svh"
module lsc_comparator
  import lsc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // stack word stream
  input  wire logic        stk_start_i,
  input  wire logic        word_valid_i,
  input  wire logic [31:0] word_i,
  input  wire logic [7:0]  base_off_i,
  input  wire logic        chan_i,
  // result
  output logic             res_valid_o,
  output logic [7:0]       res_match_o,
  output logic [7:0]       res_next_off_o,
  output logic [2:0]       res_next_cmp_o
);

  // ****************************************
  // configuration storage
  // ****************************************
  logic [2:0]  ptr_a_r;
  logic [2:0]  ptr_b_r;
  logic        mode_r;
  logic [9:0]  fctrl_r [`LSC_NFLOWS];
  lsc_label_t  low_r   [`LSC_NFLOWS][`LSC_MAXLBL];
  lsc_label_t  high_r  [`LSC_NFLOWS][`LSC_MAXLBL];

  logic        acc;
  logic        wr_ok;
  logic        fsel;
  logic [2:0]  fidx;
  logic [3:0]  fword;
  logic [1:0]  fpair;
  logic [1:0]  hpair;
  logic [31:0] g_new;
  logic [31:0] c_new;
  logic [31:0] lo_new;
  logic [31:0] hi_new;

  assign acc   = cyc_i & stb_i & ~ack_o;
  assign wr_ok = acc & we_i;
  // flow 0 sits one block above the globals, so the index is offset
  assign fsel  = adr_i >= `LSC_A_FLOWBASE && adr_i < `LSC_A_FLOWEND;
  assign fidx  = 3'(adr_i[9:6] - 4'h1);
  assign fword = adr_i[5:2];
  assign fpair = 2'(fword - `LSC_FW_LOW0);
  assign hpair = 2'(fword - `LSC_FW_HIGH0);

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel_i[b]) begin
        r[b*8 +: 8] = dat_i[b*8 +: 8];
      end
    end
    return r;
  endfunction

  assign g_new  = merge({23'h0, mode_r, 1'b0, ptr_b_r, 1'b0, ptr_a_r});
  assign c_new  = merge({22'h0, fctrl_r[fidx]});
  assign lo_new = merge({12'h0, low_r[fidx][fpair]});
  assign hi_new = merge({12'h0, high_r[fidx][hpair]});

  // shared pointers and mode, one per stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr_a_r <= `LSC_RST_PTR;
      ptr_b_r <= `LSC_RST_PTR;
      mode_r  <= 1'b0;
    end else if (wr_ok && adr_i == `LSC_A_GLOBAL) begin
      ptr_a_r <= g_new[`LSC_G_PTRA];                // [R14]
      ptr_b_r <= g_new[`LSC_G_PTRB];                // [R17]
      mode_r  <= g_new[`LSC_G_MODE];                // [R15]
    end
  end

  // per-flow match registers, eight flows in all
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int f = 0; f < `LSC_NFLOWS; f++) begin  // [R18]
        fctrl_r[f] <= `LSC_RST_CTRL;
        for (int p = 0; p < `LSC_MAXLBL; p++) begin
          low_r[f][p]  <= `LSC_RST_LOW;
          high_r[f][p] <= `LSC_RST_HIGH;
        end
      end
    end else if (wr_ok && fsel) begin
      if (fword == `LSC_FW_CTRL) begin
        fctrl_r[fidx] <= c_new[9:0];                         // [R15]
      end else if (fword < `LSC_FW_HIGH0) begin
        low_r[fidx][fpair] <= lo_new[19:0];                  // [R12]
      end else if (fword <= `LSC_FW_LAST) begin
        high_r[fidx][hpair] <= hi_new[19:0];                 // [R12]
      end
    end
  end

  // ****************************************
  // stack walker
  // ****************************************
  lsc_state_t  st_r;
  lsc_label_t  lbl_r [`LSC_MAXLBL];
  logic [2:0]  cnt_r;
  logic        deep_err_r;
  logic        cw_got_r;
  logic [3:0]  cw_top_r;
  logic [7:0]  base_r;
  logic        chan_r;
  logic        want_cw;

  // a control word is taken if any live flow expects one
  always_comb begin
    want_cw = 1'b0;
    for (int f = 0; f < `LSC_NFLOWS; f++) begin
      want_cw = want_cw | (fctrl_r[f][`LSC_F_ENA] &
                           fctrl_r[f][`LSC_F_CW]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r       <= ST_IDLE;
      cnt_r      <= 3'h0;
      deep_err_r <= 1'b0;
      cw_got_r   <= 1'b0;
      cw_top_r   <= 4'h0;
      base_r     <= 8'h00;
      chan_r     <= 1'b0;
      for (int p = 0; p < `LSC_MAXLBL; p++) begin
        lbl_r[p] <= `LSC_RST_LOW;
      end
    end else if (word_valid_i && stk_start_i) begin
      // a new stack always restarts the walk, even mid-stack
      lbl_r[0]   <= word_i[`LSC_LBL_VAL];               // [R3]
      cnt_r      <= 3'h1;
      deep_err_r <= 1'b0;
      cw_got_r   <= 1'b0;
      cw_top_r   <= 4'h0;
      base_r     <= base_off_i;
      chan_r     <= chan_i;
      if (word_i[`LSC_LBL_BOS]) begin                   // [R2]
        st_r <= want_cw ? ST_CWORD : ST_EVAL;
      end else begin
        st_r <= ST_LABEL;
      end
    end else begin
      case (st_r)
        ST_LABEL: begin
          if (word_valid_i) begin
            lbl_r[cnt_r[1:0]] <= word_i[`LSC_LBL_VAL];  // [R3]
            cnt_r <= cnt_r + 3'h1;
            if (word_i[`LSC_LBL_BOS]) begin             // [R2]
              st_r <= want_cw ? ST_CWORD : ST_EVAL;
            end else if (cnt_r == 3'(`LSC_MAXLBL - 1)) begin
              deep_err_r <= 1'b1;                       // [R1]
              st_r       <= ST_EVAL;
            end
          end
        end
        ST_CWORD: begin
          if (word_valid_i) begin
            cw_got_r <= 1'b1;
            cw_top_r <= word_i[`LSC_CW_TOP];            // [R4]
            st_r     <= ST_EVAL;
          end
        end
        ST_EVAL: st_r <= ST_IDLE;
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // flow matching
  // ****************************************
  // label at position p of the pair map, per reference point
  function automatic logic pair_ok(input int f, input int p);
    int  idx;
    logic ok;
    idx = fctrl_r[f][`LSC_F_REF] ? int'(cnt_r) + p - `LSC_MAXLBL
                                 : p;                   // [R7] [R9] [R10]
    ok = 1'b1;
    if (idx >= 0 && idx < int'(cnt_r)) begin
      ok = lbl_r[idx] >= low_r[f][p] &&
           lbl_r[idx] <= high_r[f][p];                  // [R12]
    end
    return ok;
  endfunction

  logic [7:0] hit;
  logic [7:0] hit_sel;
  logic       any_hit;
  logic       grp_sel;
  logic       cw_sel;

  always_comb begin
    for (int f = 0; f < `LSC_NFLOWS; f++) begin
      hit[f] = fctrl_r[f][`LSC_F_ENA] &&                       // [R6]
               fctrl_r[f][`LSC_F_MASK_LSB + int'(chan_r)] &&   // [R6]
               !deep_err_r && cnt_r != 3'h0 &&
               fctrl_r[f][`LSC_F_DEPTH_LSB + int'(cnt_r) - 1] && // [R8]
               (!fctrl_r[f][`LSC_F_CW] ||
                (cw_got_r && cw_top_r == 4'h0));               // [R4]
      for (int p = 0; p < `LSC_MAXLBL; p++) begin
        hit[f] = hit[f] && pair_ok(f, p);                      // [R19]
      end
    end
  end

  // mode 1 keeps only the lowest matching flow
  always_comb begin
    hit_sel = 8'h00;
    grp_sel = 1'b0;
    cw_sel  = 1'b0;
    any_hit = 1'b0;
    for (int f = `LSC_NFLOWS - 1; f >= 0; f--) begin
      if (hit[f]) begin
        hit_sel = 8'h00;
        hit_sel[f] = 1'b1;
        grp_sel = fctrl_r[f][`LSC_F_GRP];               // [R17]
        cw_sel  = fctrl_r[f][`LSC_F_CW];
        any_hit = 1'b1;
      end
    end
    if (!mode_r) begin
      hit_sel = hit;                                    // [R15]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_valid_o    <= 1'b0;
      res_match_o    <= 8'h00;
      res_next_off_o <= 8'h00;
      res_next_cmp_o <= `LSC_RST_PTR;
    end else begin
      res_valid_o <= st_r == ST_EVAL;
      if (st_r == ST_EVAL) begin
        res_match_o    <= hit_sel;                      // [R16]
        res_next_off_o <= 8'(base_r +
          {cnt_r, 2'b00} +
          ((any_hit && cw_sel) ? `LSC_WORD_BYTES : 8'h00));  // [R11]
        res_next_cmp_o <= grp_sel ? ptr_b_r : ptr_a_r;       // [R14]
      end
    end
  end

  // ****************************************
  // register read back
  // ****************************************
  logic [31:0] rd;

  always_comb begin
    rd = 32'h0;
    if (adr_i == `LSC_A_GLOBAL) begin
      rd = {23'h0, mode_r, 1'b0, ptr_b_r, 1'b0, ptr_a_r};
    end else if (adr_i == `LSC_A_STATUS) begin
      rd = {12'h0, cnt_r, deep_err_r, res_next_off_o, res_match_o};
    end else if (fsel && adr_i[1:0] == 2'h0) begin
      if (fword == `LSC_FW_CTRL) begin
        rd = {22'h0, fctrl_r[fidx]};
      end else if (fword < `LSC_FW_HIGH0) begin
        rd = {12'h0, low_r[fidx][fpair]};
      end else if (fword <= `LSC_FW_LAST) begin
        rd = {12'h0, high_r[fidx][hpair]};
      end
    end
  end

  // ack one cycle after the request, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      ack_o <= acc;
      if (acc && !we_i) begin
        dat_o <= rd;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_result_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    res_valid_o |-> $past(st_r) == ST_EVAL)  // [R1]
    else $error("result without evaluation");

  chk_depth_limit: assert property (@(posedge clk_i) disable iff (rst_i)
    cnt_r <= 3'(`LSC_MAXLBL))  // [R1]
    else $error("label count above four");

  chk_bos_stop: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r == ST_LABEL && word_valid_i && !stk_start_i &&
     word_i[`LSC_LBL_BOS]) |=> st_r != ST_LABEL)  // [R2]
    else $error("walk went on past last label");

  chk_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r == ST_EVAL) |=> ((res_match_o &
      ~{fctrl_r[7][0], fctrl_r[6][0], fctrl_r[5][0], fctrl_r[4][0],
        fctrl_r[3][0], fctrl_r[2][0], fctrl_r[1][0], fctrl_r[0][0]})
      == 8'h00 || $changed(fctrl_r[0])))  // [R6]
    else $error("disabled flow reported a match");

  chk_deep_nomatch: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r == ST_EVAL && deep_err_r) |=> res_match_o == 8'h00)  // [R8]
    else $error("overlong stack matched");

  chk_offset_calc: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r == ST_EVAL && !any_hit) |=>
      res_next_off_o == 8'($past(base_r) + {$past(cnt_r), 2'b00}))  // [R11]
    else $error("next offset wrong");

  chk_group_ptr: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r == ST_EVAL && !grp_sel && !$changed(ptr_a_r)) |=>
      res_next_cmp_o == $past(ptr_a_r))  // [R17]
    else $error("set A pointer not used");

  chk_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)  // [R15]
    else $error("bus answer not single cycle");

endmodule

/* src/lsc_defines.svh */
/*
 * constants for the label stack comparator: register map, field
 * positions, reset values and sizes.
 * assumes a 32-bit classic wishbone slave with byte addresses.
 */
// What this block does
// R1: accept a stack of one to four labels, 32 bits each.
// R2: bottom bit 0 means another label follows, 1 means last label.
// R3: label is value[31:12], class[11:9], bottom[8], ttl[7:0].
// R4: with control word set, expect a word after stack, upper 4 bits zero.
// R5: software sets control word only when no channel header follows.
// R6: flow matches only when enabled and its channel mask bit set.
// R7: reference bit picks top-of-stack (0) or end-of-stack (1) search.
// R8: depth mask bit n permits depth n+1, else no match.
// R9: top reference: pairs 0..3 cover top label and next three.
// R10: end reference: pair 3 is end label, 2,1,0 the ones before.
// R11: next offset from label count and control word, past last word.
// R12: four 20-bit low/high pairs per flow, label must lie within.
// R13: software loads equal bounds for exact, 0..max for don't care.
// R14: one shared 3-bit next comparator pointer per set.
// R15: one shared match mode; each flow has its own match registers.
// R16: only labels and control word are examined here.
// R17: two next-protocol sets; per-flow bit selects set A or B.
// R18: at most eight flows shared between the two sets.
// R19: match needs enable, mask, depth, all ranges and control word.
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH

`define LSC_NFLOWS      8
`define LSC_NCHAN       2
`define LSC_MAXLBL      4
`define LSC_WORD_BYTES  8'h04

// label and control word fields
`define LSC_LBL_VAL     31:12
`define LSC_LBL_BOS     8
`define LSC_CW_TOP      31:28

// register map: byte addresses, then word indices inside a flow block
`define LSC_A_GLOBAL    10'h000
`define LSC_A_STATUS    10'h004
`define LSC_A_FLOWBASE  10'h040
`define LSC_A_FLOWEND   10'h240
`define LSC_FW_CTRL     4'h0
`define LSC_FW_LOW0     4'h1
`define LSC_FW_HIGH0    4'h5
`define LSC_FW_LAST     4'h8

// global register fields
`define LSC_G_PTRA      2:0
`define LSC_G_PTRB      6:4
`define LSC_G_MODE      8

// per-flow control fields
`define LSC_F_ENA       0
`define LSC_F_MASK      2:1
`define LSC_F_MASK_LSB  1
`define LSC_F_DEPTH_LSB 5
`define LSC_F_CW        3
`define LSC_F_REF       4
`define LSC_F_DEPTH     8:5
`define LSC_F_GRP       9

`define LSC_RST_PTR     3'h0
`define LSC_RST_CTRL    10'h000
`define LSC_RST_LOW     20'h00000
`define LSC_RST_HIGH    20'hFFFFF

`endif

/* src/lsc_pkg.sv */
/*
 * types shared by the label stack comparator.
 * assumes lsc_defines.svh for the sizes.
 */
`include "lsc_defines.svh"
package lsc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LABEL,
    ST_CWORD,
    ST_EVAL
  } lsc_state_t;
  typedef logic [19:0] lsc_label_t;
endpackage

/* tb/lsc_comparator_bench.sv */
/*
 * self-checking bench for the label stack comparator.
 * assumes the stream model lsc_stream_src and the design's map.
 */
`timescale 1ns/100ps
module lsc_comparator_bench;
  typedef struct {
    logic            c;
    int              n;
    logic [3:0][19:0] v;
    logic [31:0]     cw;
    logic [7:0]      m;
    logic [7:0]      off;
    logic [2:0]      p;
  } lsc_row_t;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [9:0]  adr_i = 10'h0;
  logic [3:0]  sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, word_i, d;
  logic        ack_o, stk_start_i, word_valid_i, chan_i, res_valid_o;
  logic [7:0]  base_off_i, res_match_o, res_next_off_o;
  logic [2:0]  res_next_cmp_o;
  logic [31:0] w[6];
  lsc_row_t    rows[10];
  lsc_row_t    r;
  int          miscompares = 0;
  int          cmp_count = 0;

  always #20 clk_i = ~clk_i;

  lsc_comparator dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .stk_start_i, .word_valid_i, .word_i,
    .base_off_i, .chan_i, .res_valid_o, .res_match_o, .res_next_off_o,
    .res_next_cmp_o);

  lsc_stream_src src (.clk_i, .stk_start_o(stk_start_i),
    .word_valid_o(word_valid_i), .word_o(word_i),
    .base_off_o(base_off_i), .chan_o(chan_i));

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string s);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask

  task automatic wb(input logic wr, input logic [9:0] a,
                    input logic [31:0] v, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= a;
    dat_i <= v;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (k >= 20) chk(0, 1, "no ack");
  endtask

  // class and ttl nonzero so a slipped field shows up in the value
  function automatic logic [31:0] lbl(logic [19:0] v, logic s);
    return {v, 3'h5, s, 8'h3F};
  endfunction

  task automatic wait_res;
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (res_valid_o !== 1'b1 && k < 20);
    #1;
    chk(k < 20, 1, "no result");
  endtask

  task automatic run(input lsc_row_t x, input int gap);
    for (int i = 0; i < x.n; i++) w[i] = lbl(x.v[i], i == x.n - 1);
    w[x.n] = x.cw;
    src.send(w, x.n + 1, 8'h0E, x.c, gap);
    wait_res();
    chk(res_match_o, x.m, "match");
    if (x.m != 8'h0) chk(res_next_off_o, x.off, "offset");
    chk(res_next_cmp_o, x.p, "next cmp");
  endtask

  task automatic complete_run;
    if (miscompares == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk_i);
    miscompares++;
    complete_run();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rows[0] = '{0, 1, {60'h0, 20'h150}, 0, 8'h01, 8'h12, 3'h5};
    rows[1] = '{0, 2, {40'h0, 20'hABC, 20'h150}, 0, 8'h03, 8'h16, 3'h5};
    rows[2] = '{1, 2, {40'h0, 20'hABC, 20'h150}, 0, 8'h02, 8'h1A, 3'h2};
    rows[3] = '{1, 2, {40'h0, 20'hABD, 20'h150}, 0, 8'h00, 8'h0, 3'h5};
    rows[4] = '{1, 2, {40'h0, 20'hABC, 20'h150}, 32'h1000_0000, 0, 0, 5};
    rows[5] = '{1, 2, {40'h0, 20'h150, 20'hABC}, 0, 8'h00, 8'h0, 3'h5};
    rows[6] = '{0, 4, {20'h3, 20'h2, 20'h1, 20'h150}, 0, 1, 8'h1E, 5};
    rows[7] = '{0, 1, {60'h0, 20'h0FF}, 0, 8'h00, 8'h0, 3'h5};
    rows[8] = '{0, 1, {60'h0, 20'h1FF}, 0, 8'h01, 8'h12, 3'h5};
    rows[9] = '{1, 3, {20'h0, 20'hABC, 20'h0, 20'h150}, 0, 0, 0, 5};
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, 10'h040, 0, d);
    chk(d, 32'h0, "ctrl reset");
    wb(0, 10'h044, 0, d);
    chk(d, 32'h0, "low reset");
    wb(0, 10'h054, 0, d);
    chk(d, 32'hFFFFF, "high reset");
    wb(0, 10'h000, 0, d);
    chk(d, 32'h0, "global reset");
    wb(1, 10'h000, 32'h25, d);
    wb(1, 10'h040, 32'h1E3, d);
    wb(1, 10'h044, 32'h100, d);
    wb(1, 10'h054, 32'h1FF, d);
    wb(1, 10'h080, 32'h25F, d);
    wb(1, 10'h090, 32'hABC, d);
    wb(1, 10'h0A0, 32'hABC, d);
    wb(1, 10'h0C0, 32'h1E6, d);
    wb(0, 10'h080, 0, d);
    chk(d, 32'h25F, "ctrl readback");
    wb(1, 10'h200, 32'h3FF, d);
    wb(0, 10'h200, 0, d);
    chk(d, 32'h3FF, "last flow ctrl");
    wb(1, 10'h200, 32'h0, d);
    wb(1, 10'h010, 32'hFFFF_FFFF, d);
    wb(0, 10'h010, 0, d);
    chk(d, 32'h0, "unmapped");
    // rows: depth mask, ranges, reference point, control word, channel
    for (int i = 0; i < 10; i++) run(rows[i], i % 2);
    // single-match mode keeps only the lowest flow
    wb(1, 10'h000, 32'h125, d);
    r = rows[1];
    r.m = 8'h01;
    run(r, 0);
    wb(0, 10'h004, 0, d);
    chk(d, 32'h41601, "status");
    // four labels without a bottom bit: depth error
    for (int i = 0; i < 6; i++) w[i] = lbl(20'h150, 1'b0);
    src.send(w, 5, 8'h0E, 1'b0, 0);
    wait_res();
    chk(res_match_o, 8'h0, "depth error");
    wb(0, 10'h004, 0, d);
    chk(d, 32'h91E00, "depth status");
    // second reset in mid-run
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(posedge clk_i);
    @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    chk(res_match_o, 8'h0, "match after reset");
    wb(0, 10'h080, 0, d);
    chk(d, 32'h0, "ctrl after reset");
    complete_run();
  end
endmodule

/* tb/lsc_stream_src.sv */
/*
 * model of the previous comparator stage: hands a label stack to the
 * comparator one word per valid cycle, optionally with idle gaps.
 * assumes the comparator's clock and no back-pressure on the stream.
 */
`timescale 1ns/100ps
module lsc_stream_src (
  // clock
  input  wire logic        clk_i,
  // stack word stream
  output logic             stk_start_o,
  output logic             word_valid_o,
  output logic [31:0]      word_o,
  output logic [7:0]       base_off_o,
  output logic             chan_o
);
  initial begin
    stk_start_o = 1'b0;
    word_valid_o = 1'b0;
    word_o = 32'h0;
    base_off_o = 8'h0;
    chan_o = 1'b0;
  end

  // idle data is inverted so a stale word never passes for a fresh one
  task automatic send(input logic [31:0] w[6], input int n,
                      input logic [7:0] b, input logic c, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      stk_start_o  <= (i == 0);
      word_valid_o <= 1'b1;
      word_o       <= w[i];
      base_off_o   <= (i == 0) ? b : ~b;
      chan_o       <= (i == 0) ? c : ~c;
      repeat (gap) begin
        @(posedge clk_i);
        stk_start_o  <= 1'b0;
        word_valid_o <= 1'b0;
        word_o       <= ~w[i];
      end
    end
    @(posedge clk_i);
    stk_start_o  <= 1'b0;
    word_valid_o <= 1'b0;
    word_o       <= ~w[n-1];
  endtask
endmodule
